// ### hdl/flash_command_status_control.sv
// flash program/erase command sequencer: configuration, protection, status and command registers
`timescale 1ns/1ps

// Function
// RULE1: key enable clear: window write starts command
// RULE2: key enable set: window writes capture key
// RULE3: protection loads from stored byte; readable
// RULE4: disable set all writable; else grow only
// RULE5: shrinking protection writes ignored entirely
// RULE6: boundary field marks unprotected high-end limit
// RULE7: protection disable bit zero blocks region
// RULE8: writing one to buffer-empty launches, clears
// RULE9: only burst program buffered; flag shows room
// RULE10: complete flag when idle; clears on launch
// RULE11: protected target sets violation, discards command
// RULE12: sequence, divider, stop errors set access error
// RULE13: blank flag set on all-erased check
// RULE14: decode blank, byte program, burst program codes
// RULE15: decode page erase and mass erase codes
// RULE16: other codes rejected with access error
// RULE17: blank check after mass erase optional
// RULE18: first divider write sets loaded flag
// RULE19: successful blank check sets unsecured code
// RULE20: unimplemented config/status bits read zero
module flash_command_status_control #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	// register port
	input  wire logic [3:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	// cpu writes into flash address space
	input  wire logic                      mem_wr,
	input  wire logic [ADDR_W-1:0]         mem_addr,
	input  wire logic [7:0]                mem_wdata,
	// nonvolatile stored protection byte
	input  wire logic [7:0]                stored_protection_byte,
	// stop mode entry
	input  wire logic                      stop_entry,
	// array side
	output flash_ctl_pkg::flash_cmd_t      array_cmd,
	input  wire logic                      array_all_erased,
	// key compare output
	output logic                           key_byte_valid,
	output logic      [2:0]                key_byte_index,
	output logic      [7:0]                key_byte_data,
	// status
	output logic      [1:0]                security_state_code
);

	flash_ctl_pkg::ctl_state_t s_r;
	flash_ctl_pkg::ctl_state_t s_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic legal_code(input logic [7:0] c);
		legal_code = (c == flash_ctl_pkg::CMD_BLANK_CHECK) || (c == flash_ctl_pkg::CMD_BYTE_PROGRAM) ||
			(c == flash_ctl_pkg::CMD_BURST_PROG) || (c == flash_ctl_pkg::CMD_PAGE_ERASE) ||
			(c == flash_ctl_pkg::CMD_MASS_ERASE);
	endfunction : legal_code

	function automatic logic modifies(input logic [7:0] c);
		modifies = (c != flash_ctl_pkg::CMD_BLANK_CHECK);
	endfunction : modifies

	// protected when address above boundary limit at the high end
	function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [7:0] c,
		input logic [6:0] b, input logic dis);
		logic [ADDR_W-1:0] limit;
		limit = ADDR_W'({b, {flash_ctl_pkg::PROT_SHIFT{1'b1}}});
		if (dis)
			is_protected = 1'b0;
		else if (c == flash_ctl_pkg::CMD_MASS_ERASE)
			is_protected = 1'b1;
		else
			is_protected = (a > limit); // RULE6
	endfunction : is_protected

	logic in_window;
	assign in_window = (16'(mem_addr) >= flash_ctl_pkg::KEY_BASE) && (16'(mem_addr) <= flash_ctl_pkg::KEY_LAST);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [7:0] w;
		logic       launch;
		logic       busy;
		logic       done;
		logic       mem_err;
		w       = reg_wdata;
		s_nxt   = s_r;
		launch  = 1'b0;
		done    = 1'b0;
		busy    = 1'b0;
		mem_err = 1'b0;
		s_nxt.key_valid = 1'b0;
		s_nxt.rdata     = 8'h00;

		if (!s_r.prot_loaded)
		begin
			s_nxt.boundary     = stored_protection_byte[7:1]; // RULE3
			s_nxt.prot_disable = stored_protection_byte[0];
			s_nxt.prot_loaded  = 1'b1;
		end

		// array execution
		if (s_r.active.valid)
		begin
			if (s_r.exec_cnt == 8'h00)
			begin
				done = 1'b1;
				if (s_r.active.cmd == flash_ctl_pkg::CMD_BLANK_CHECK && array_all_erased)
				begin
					s_nxt.blank    = 1'b1; // RULE13
					s_nxt.security = flash_ctl_pkg::SEC_UNSECURE; // RULE19
				end
				s_nxt.active.valid = 1'b0;
			end
			else
				s_nxt.exec_cnt = s_r.exec_cnt - 8'h01;
		end
		if ((done || !s_r.active.valid) && s_r.buffered.valid)
		begin
			s_nxt.active          = s_r.buffered;
			s_nxt.exec_cnt        = flash_ctl_pkg::EXEC_CYCLES;
			s_nxt.buffered.valid  = 1'b0;
			s_nxt.cbef            = 1'b1; // RULE9
		end

		// cpu writes into the flash space
		if (mem_wr)
		begin
			if (s_r.key_write_en && in_window)
			begin
				s_nxt.key_valid = 1'b1; // RULE2
				s_nxt.key_index = mem_addr[2:0];
				s_nxt.key_data  = mem_wdata;
			end
			else if (s_r.seq == flash_ctl_pkg::SEQ_IDLE && s_r.cbef)
			begin
				s_nxt.pending.addr  = 16'(mem_addr); // RULE1
				s_nxt.pending.data  = mem_wdata;
				s_nxt.seq           = flash_ctl_pkg::SEQ_ADDR;
			end
			else
			begin
				s_nxt.accerr = 1'b1; // RULE12
				s_nxt.seq    = flash_ctl_pkg::SEQ_IDLE;
				mem_err      = 1'b1;
			end
		end

		// register writes
		if (reg_wr)
		begin
			if (reg_addr == flash_ctl_pkg::OFS_CONFIG)
				s_nxt.key_write_en = w[flash_ctl_pkg::CFG_KEY_WRITE_EN]; // RULE20
			else if (reg_addr == flash_ctl_pkg::OFS_PROTECTION)
			begin
				if (s_r.prot_disable)
				begin
					s_nxt.boundary     = w[7:1]; // RULE4
					s_nxt.prot_disable = w[0];
				end
				else if (w[7:1] <= s_r.boundary && !w[0])
					s_nxt.boundary = w[7:1]; // RULE5
			end
			else if (reg_addr == flash_ctl_pkg::OFS_COMMAND)
			begin
				if (s_r.seq == flash_ctl_pkg::SEQ_ADDR)
				begin
					s_nxt.command_code = w;
					s_nxt.pending.cmd  = w;
					s_nxt.seq          = flash_ctl_pkg::SEQ_ARMED;
				end
				else
				begin
					s_nxt.accerr = 1'b1; // RULE12
					s_nxt.seq    = flash_ctl_pkg::SEQ_IDLE;
				end
			end
			else if (reg_addr == flash_ctl_pkg::OFS_DIVIDER)
			begin
				s_nxt.divider    = w[6:0] & flash_ctl_pkg::DIV_WMASK[6:0];
				s_nxt.div_loaded = 1'b1; // RULE18
			end
			else if (reg_addr == flash_ctl_pkg::OFS_STATUS)
			begin
				if (w[flash_ctl_pkg::ST_PVIOL])
					s_nxt.pviol = 1'b0; // RULE11
				if (w[flash_ctl_pkg::ST_ACCERR] && !mem_err)
					s_nxt.accerr = 1'b0; // RULE12
				if (w[flash_ctl_pkg::ST_CBEF])
				begin
					s_nxt.seq = flash_ctl_pkg::SEQ_IDLE;
					if (s_r.seq != flash_ctl_pkg::SEQ_ARMED || s_r.pviol || s_r.accerr)
						s_nxt.accerr = 1'b1; // RULE12
					else if (!legal_code(s_r.pending.cmd))
						s_nxt.accerr = 1'b1; // RULE16
					else if (modifies(s_r.pending.cmd) && !s_r.div_loaded)
						s_nxt.accerr = 1'b1; // RULE18
					else if (modifies(s_r.pending.cmd) &&
						is_protected(ADDR_W'(s_r.pending.addr), s_r.pending.cmd, s_r.boundary, s_r.prot_disable))
						s_nxt.pviol = 1'b1; // RULE7 RULE11
					else
						launch = 1'b1; // RULE14 RULE15
				end
			end
		end

		// launch: buffer burst only, others need an idle array
		if (launch)
		begin
			s_nxt.cbef           = 1'b0; // RULE8
			s_nxt.ccf            = 1'b0; // RULE10
			s_nxt.blank          = 1'b0; // RULE13
			s_nxt.pending.valid  = 1'b1;
			busy = s_r.active.valid && !done;
			if (!busy)
			begin
				s_nxt.active   = s_nxt.pending;
				s_nxt.exec_cnt = flash_ctl_pkg::EXEC_CYCLES;
				s_nxt.cbef     = 1'b1;
			end
			else if (s_r.pending.cmd == flash_ctl_pkg::CMD_BURST_PROG &&
				s_r.active.cmd == flash_ctl_pkg::CMD_BURST_PROG)
				s_nxt.buffered = s_nxt.pending; // RULE9
			else
			begin
				s_nxt.accerr = 1'b1;
				s_nxt.cbef   = s_r.cbef;
			end
		end

		// stop while busy aborts
		if (stop_entry && (s_r.active.valid || s_r.buffered.valid))
		begin
			s_nxt.accerr         = 1'b1; // RULE12
			s_nxt.active.valid   = 1'b0;
			s_nxt.buffered.valid = 1'b0;
			s_nxt.cbef           = 1'b1;
		end

		if (!s_nxt.active.valid && !s_nxt.buffered.valid && !launch)
			s_nxt.ccf = 1'b1; // RULE10

		// register reads, one cycle later
		if (reg_rd)
		begin
			if (reg_addr == flash_ctl_pkg::OFS_CONFIG)
				s_nxt.rdata = {2'h0, s_r.key_write_en, 5'h00}; // RULE20
			else if (reg_addr == flash_ctl_pkg::OFS_PROTECTION)
				s_nxt.rdata = {s_r.boundary, s_r.prot_disable}; // RULE3
			else if (reg_addr == flash_ctl_pkg::OFS_STATUS)
				s_nxt.rdata = {s_r.cbef, s_r.ccf, s_r.pviol, s_r.accerr, 1'b0, s_r.blank, 2'h0};
			else if (reg_addr == flash_ctl_pkg::OFS_COMMAND)
				s_nxt.rdata = s_r.command_code;
			else if (reg_addr == flash_ctl_pkg::OFS_DIVIDER)
				s_nxt.rdata = {s_r.div_loaded, s_r.divider};
			else if (reg_addr == flash_ctl_pkg::OFS_SECURITY)
				s_nxt.rdata = {6'h00, s_r.security};
			else
				s_nxt.rdata = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			s_r          <= '0;
			s_r.cbef     <= 1'b1;
			s_r.ccf      <= 1'b1;
			s_r.security <= flash_ctl_pkg::SEC_RESET;
			s_r.seq      <= flash_ctl_pkg::SEQ_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata           = s_r.rdata;
	assign array_cmd           = s_r.active;
	assign key_byte_valid      = s_r.key_valid;
	assign key_byte_index      = s_r.key_index;
	assign key_byte_data       = s_r.key_data;
	assign security_state_code = s_r.security;

endmodule : flash_command_status_control

// ### hdl/flash_ctl_pkg.sv
// package: register map, field positions, command codes and state for the flash command/status block
package flash_ctl_pkg;

	// register offsets on the plain register port
	localparam logic [3:0] OFS_CONFIG     = 4'h0;
	localparam logic [3:0] OFS_PROTECTION = 4'h1;
	localparam logic [3:0] OFS_STATUS     = 4'h2;
	localparam logic [3:0] OFS_COMMAND    = 4'h3;
	localparam logic [3:0] OFS_DIVIDER    = 4'h4;
	localparam logic [3:0] OFS_SECURITY   = 4'h5;

	// field positions
	localparam int CFG_KEY_WRITE_EN   = 5;
	localparam int PROT_DISABLE       = 0;
	localparam int ST_CBEF            = 7;
	localparam int ST_CCF             = 6;
	localparam int ST_PVIOL           = 5;
	localparam int ST_ACCERR          = 4;
	localparam int ST_BLANK           = 2;
	localparam int DIV_LOADED         = 7;

	// writable masks, security reset and unsecured codes
	localparam logic [7:0] CFG_MASK     = 8'h20;
	localparam logic [7:0] DIV_WMASK    = 8'h7f;
	localparam logic [1:0] SEC_UNSECURE = 2'h2;
	localparam logic [1:0] SEC_RESET    = 2'h0;

	// backdoor key window
	localparam logic [15:0] KEY_BASE = 16'hffb0;
	localparam logic [15:0] KEY_LAST = 16'hffb7;

	// command codes
	localparam logic [7:0] CMD_BLANK_CHECK  = 8'h05;
	localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h20;
	localparam logic [7:0] CMD_BURST_PROG   = 8'h25;
	localparam logic [7:0] CMD_PAGE_ERASE   = 8'h40;
	localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;

	// page size and protection granularity
	localparam int PAGE_BYTES = 512;
	localparam int PROT_SHIFT = 9;

	// execution time of one command in cycles
	localparam logic [7:0] EXEC_CYCLES = 8'h10;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ADDR,
		SEQ_ARMED
	} seq_state_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  data;
	} flash_cmd_t;

	typedef struct packed {
		logic [7:0]  rdata;
		logic        key_write_en;
		logic [6:0]  boundary;
		logic        prot_disable;
		logic        cbef;
		logic        ccf;
		logic        pviol;
		logic        accerr;
		logic        blank;
		logic        div_loaded;
		logic [6:0]  divider;
		logic [1:0]  security;
		logic [7:0]  command_code;
		seq_state_t  seq;
		flash_cmd_t  pending;
		flash_cmd_t  buffered;
		flash_cmd_t  active;
		logic [7:0]  exec_cnt;
		logic        key_valid;
		logic [2:0]  key_index;
		logic [7:0]  key_data;
		logic        prot_loaded;
	} ctl_state_t;

endpackage : flash_ctl_pkg

// ### testbench/flash_ctl_checker.sv
// checker: port-level assertions for the flash command/status block
`timescale 1ns/1ps
module flash_ctl_checker #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic                       sys_clk,
	input wire logic                       rstn,
	// register port
	input wire logic [3:0]                 reg_addr,
	input wire logic [7:0]                 reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [7:0]                 reg_rdata,
	// flash-space writes
	input wire logic                       mem_wr,
	input wire logic [ADDR_W-1:0]          mem_addr,
	input wire logic [7:0]                 mem_wdata,
	// array and key side
	input wire flash_ctl_pkg::flash_cmd_t  array_cmd,
	input wire logic                       key_byte_valid,
	input wire logic [2:0]                 key_byte_index,
	input wire logic [7:0]                 key_byte_data,
	input wire logic [1:0]                 security_state_code
);
	logic key_en_r;
	logic blank_seen_r;
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			key_en_r     <= 1'b0;
			blank_seen_r <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == flash_ctl_pkg::OFS_CONFIG)
				key_en_r <= reg_wdata[flash_ctl_pkg::CFG_KEY_WRITE_EN];
			if (array_cmd.valid && array_cmd.cmd == flash_ctl_pkg::CMD_BLANK_CHECK)
				blank_seen_r <= 1'b1;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_key_write;
		mem_wr && key_en_r && mem_addr >= flash_ctl_pkg::KEY_BASE && mem_addr <= flash_ctl_pkg::KEY_LAST;
	endsequence
	sequence s_status_read;
		reg_rd && reg_addr == flash_ctl_pkg::OFS_STATUS;
	endsequence
	a_key_capture: assert property (s_key_write |=> key_byte_valid && key_byte_data == $past(mem_wdata) && key_byte_index == $past(mem_addr[2:0])) else $error("key byte not captured");
	a_key_cause: assert property (key_byte_valid |-> $past(mem_wr) && $past(key_en_r)) else $error("key byte without key write");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
	a_unmapped_read: assert property (reg_rd && reg_addr > flash_ctl_pkg::OFS_SECURITY |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_status_unused: assert property (s_status_read |=> reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'h0) else $error("status unused bits set");
	a_config_unused: assert property (reg_rd && reg_addr == flash_ctl_pkg::OFS_CONFIG |=> (reg_rdata & ~flash_ctl_pkg::CFG_MASK) == 8'h00) else $error("config unused bits set");
	a_ccf_busy: assert property (s_status_read and array_cmd.valid |=> !reg_rdata[flash_ctl_pkg::ST_CCF]) else $error("complete flag while busy");
	a_array_hold: assert property ($rose(array_cmd.valid) |-> array_cmd.valid[*8]) else $error("command dropped early");
	a_sec_after_blank: assert property (security_state_code != flash_ctl_pkg::SEC_RESET |-> blank_seen_r && security_state_code == flash_ctl_pkg::SEC_UNSECURE) else $error("security code without blank check");
endmodule : flash_ctl_checker

// ### testbench/cpu_model.sv
// cpu model: register port and flash-space write cycles
`timescale 1ns/1ps
module cpu_model (
	// clock
	input  wire logic        sys_clk,
	// register port
	output logic      [3:0]  reg_addr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [7:0]  reg_rdata,
	// flash-space writes
	output logic             mem_wr,
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata
);
	initial
	begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, mem_wr, mem_addr, mem_wdata} = '0;
	end
	task reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask : reg_write
	task reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	task mem_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		mem_addr  <= a;
		mem_wdata <= d;
		mem_wr    <= 1'b1;
		@(posedge sys_clk);
		mem_wr    <= 1'b0;
	endtask : mem_write
endmodule : cpu_model

// ### testbench/flash_command_status_control_test.sv
// testbench: register-level sequences against the flash command/status block
`timescale 1ns/1ps
module flash_command_status_control_test;
	logic                      sys_clk;
	logic                      rstn;
	logic                      erased;
	logic                      stop;
	logic [3:0]                reg_addr;
	logic [7:0]                reg_wdata;
	logic                      reg_wr;
	logic                      reg_rd;
	logic [7:0]                reg_rdata;
	logic                      mem_wr;
	logic [15:0]               mem_addr;
	logic [7:0]                mem_wdata;
	flash_ctl_pkg::flash_cmd_t array_cmd;
	logic                      kv;
	logic [2:0]                ki;
	logic [7:0]                kd;
	logic [1:0]                sec;
	logic [7:0]                rd;
	logic [7:0]                codes [5];
	int                        failures = 0;
	int                        n_tests = 0;
	int                        cycles = 0;
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	cpu_model i_cpu (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
	flash_command_status_control #(.ADDR_W(16)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .stored_protection_byte(8'h81), .stop_entry(stop),
		.array_cmd(array_cmd), .array_all_erased(erased), .key_byte_valid(kv), .key_byte_index(ki),
		.key_byte_data(kd), .security_state_code(sec));
	task print_verdict();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task rd_chk(input logic [3:0] a, input logic [7:0] exp);
		i_cpu.reg_read(a, rd);
		check(rd, exp);
	endtask : rd_chk
	task launch(input logic [15:0] a, input logic [7:0] code);
		i_cpu.mem_write(a, 8'h3c);
		i_cpu.reg_write(flash_ctl_pkg::OFS_COMMAND, code);
		i_cpu.reg_write(flash_ctl_pkg::OFS_STATUS, 8'h80);
	endtask : launch
	task wait_idle(input logic [7:0] exp);
		rd = 8'h00;
		for (int i = 0; i < 40 && rd[6] !== 1'b1; i++)
			i_cpu.reg_read(flash_ctl_pkg::OFS_STATUS, rd);
		check(rd, exp);
	endtask : wait_idle
	task do_cmd(input logic [15:0] a, input logic [7:0] code, input logic ok, input logic [7:0] exp);
		launch(a, code);
		#1 check({array_cmd.valid, 7'h0}, {ok, 7'h0});
		if (ok)
		begin
			check(array_cmd.cmd, code);
			check(array_cmd.data, 8'h3c);
			check(array_cmd.addr[15:8], a[15:8]);
			check(array_cmd.addr[7:0], a[7:0]);
		end
		wait_idle(exp);
	endtask : do_cmd
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			print_verdict();
		end
	end
	initial
	begin
		rstn   = 1'b0;
		erased = 1'b1;
		stop   = 1'b0;
		codes  = '{flash_ctl_pkg::CMD_BLANK_CHECK, flash_ctl_pkg::CMD_BYTE_PROGRAM, flash_ctl_pkg::CMD_BURST_PROG,
			flash_ctl_pkg::CMD_PAGE_ERASE, flash_ctl_pkg::CMD_MASS_ERASE};
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd_chk(flash_ctl_pkg::OFS_STATUS, 8'hc0);
		rd_chk(flash_ctl_pkg::OFS_PROTECTION, 8'h81);
		rd_chk(4'hf, 8'h00);
		do_cmd(16'h1000, flash_ctl_pkg::CMD_BYTE_PROGRAM, 1'b0, 8'hd0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_STATUS, 8'h10);
		rd_chk(flash_ctl_pkg::OFS_STATUS, 8'hc0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_DIVIDER, 8'h00);
		rd_chk(flash_ctl_pkg::OFS_DIVIDER, 8'h80);
		do_cmd(16'h1000, 8'h33, 1'b0, 8'hd0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_STATUS, 8'h10);
		foreach (codes[i])
			do_cmd(16'h1000, codes[i], 1'b1, (i == 0) ? 8'hc4 : 8'hc0);
		check({6'h0, sec}, 8'h02);
		launch(16'h1000, flash_ctl_pkg::CMD_BYTE_PROGRAM);
		repeat (10) @(posedge sys_clk);
		stop <= 1'b1;
		@(posedge sys_clk);
		stop <= 1'b0;
		#1 check({array_cmd.valid, 7'h0}, 8'h00);
		wait_idle(8'hd0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_STATUS, 8'h10);
		launch(16'h0200, flash_ctl_pkg::CMD_BURST_PROG);
		launch(16'h0201, flash_ctl_pkg::CMD_BURST_PROG);
		rd_chk(flash_ctl_pkg::OFS_STATUS, 8'h00);
		wait_idle(8'hc0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_PROTECTION, 8'h80);
		rd_chk(flash_ctl_pkg::OFS_PROTECTION, 8'h80);
		i_cpu.reg_write(flash_ctl_pkg::OFS_PROTECTION, 8'ha0);
		rd_chk(flash_ctl_pkg::OFS_PROTECTION, 8'h80);
		i_cpu.reg_write(flash_ctl_pkg::OFS_PROTECTION, 8'h20);
		rd_chk(flash_ctl_pkg::OFS_PROTECTION, 8'h20);
		do_cmd(16'hf000, flash_ctl_pkg::CMD_BYTE_PROGRAM, 1'b0, 8'he0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_STATUS, 8'h20);
		do_cmd(16'h0100, flash_ctl_pkg::CMD_BYTE_PROGRAM, 1'b1, 8'hc0);
		do_cmd(16'h0000, flash_ctl_pkg::CMD_MASS_ERASE, 1'b0, 8'he0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_STATUS, 8'h20);
		i_cpu.reg_write(flash_ctl_pkg::OFS_CONFIG, 8'hff);
		rd_chk(flash_ctl_pkg::OFS_CONFIG, 8'h20);
		i_cpu.mem_write(16'hffb3, 8'h5a);
		#1 check({kv, ki, 4'h0}, 8'hb0);
		check(kd, 8'h5a);
		rd_chk(flash_ctl_pkg::OFS_STATUS, 8'hc0);
		i_cpu.reg_write(flash_ctl_pkg::OFS_CONFIG, 8'h00);
		do_cmd(16'hffb0, flash_ctl_pkg::CMD_BYTE_PROGRAM, 1'b0, 8'he0);
		print_verdict();
	end
endmodule : flash_command_status_control_test
bind flash_command_status_control flash_ctl_checker #(.ADDR_W(ADDR_W)) i_chk (.sys_clk(sys_clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .array_cmd(array_cmd),
	.key_byte_valid(key_byte_valid), .key_byte_index(key_byte_index), .key_byte_data(key_byte_data),
	.security_state_code(security_state_code));
